// ---- verilog/chg_pkg.sv ----
// shared constants and types for the charger two-wire target port and its controller
// Functional notes
// - answer only at target address 0x6b
// - reads above 0x25 return 0xff
// - standard 100k and fast 400k rates
// - data changes only while clock low
// - detect start and stop while clock high
// - controller alone makes start and stop
// - bus busy from start until stop
// - eight bits msb first, then ack
// - target may stretch clock while not ready
// - controller drives every clock, ninth included
// - sender releases data, receiver pulls low
// - high ninth bit is nack, then stop/restart
// - first byte is address plus direction
// - undefined register pointer gets nack, idle
// - bursts advance pointer across register boundaries
// - no limit on bytes per transfer
// - drive lines low or release, never high
package chg_pkg;
  localparam logic [6:0] TGT_ADDR = 7'h6b;
  localparam logic [7:0] REG_LAST = 8'h25;
  localparam int REG_COUNT = 38;
  localparam int REG_IDX_W = 6;
  localparam logic [7:0] RD_FILL = 8'hff;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] LINES_IDLE = 2'h3;
  localparam int LN_SCL = 0;
  localparam int LN_SDA = 1;
  // bus timing, quarter bit period rounded up so the rate never exceeds the limit
  localparam int CLK_PERIOD_NS = 50;
  localparam int STD_BIT_NS = 10000;
  localparam int FAST_BIT_NS = 2500;
  localparam int QTR_DIV = 4 * CLK_PERIOD_NS;
  localparam int STD_QTR_CYC = (STD_BIT_NS + QTR_DIV - 1) / QTR_DIV;
  localparam int FAST_QTR_CYC = (FAST_BIT_NS + QTR_DIV - 1) / QTR_DIV;
  localparam logic [7:0] STD_QTR = 8'(STD_QTR_CYC);
  localparam logic [7:0] FAST_QTR = 8'(FAST_QTR_CYC);
  localparam int FIFO_DEPTH = 32;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } chg_wr_word_t;
  localparam int FIFO_WIDTH = $bits(chg_wr_word_t);
  typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2,
                            OP_READ = 2'h3} chg_op_t;
  typedef enum logic [4:0] {T_IDLE = 5'h01, T_ADDR = 5'h02, T_PTR = 5'h04,
                            T_WDATA = 5'h08, T_RDATA = 5'h10} chg_tst_t;
  typedef enum logic [3:0] {C_IDLE = 4'h1, C_START = 4'h2, C_STOP = 4'h4,
                            C_BYTE = 4'h8} chg_cst_t;
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_LOW = 2'h1;
  localparam logic [1:0] PH_WAIT = 2'h2;
  localparam logic [1:0] PH_HIGH = 2'h3;
endpackage : chg_pkg

// ---- verilog/chg_i2c_if.sv ----
// open-drain two-wire link joining controller and target
interface chg_i2c_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_scl_o;
  logic tgt_scl_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and with pull-up: a released line reads high
  assign scl = (ctl_scl_oe_n | ctl_scl_o) & (tgt_scl_oe_n | tgt_scl_o);
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);
  modport ctl (output ctl_scl_o, ctl_scl_oe_n, ctl_sda_o, ctl_sda_oe_n, input scl, sda);
  modport tgt (output tgt_scl_o, tgt_scl_oe_n, tgt_sda_o, tgt_sda_oe_n, input scl, sda);
endinterface : chg_i2c_if

// ---- verilog/chg_fifo.sv ----
// synchronous fifo with valid/ready on both sides
module chg_fifo #(
  parameter int WIDTH = chg_pkg::FIFO_WIDTH,
  parameter int DEPTH = chg_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import chg_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } chg_fifo_st_t;
  chg_fifo_st_t q;
  chg_fifo_st_t d;
  logic full;
  // extra pointer bit tells full from empty without a counter
  assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = (q.wr != q.rd);
  assign out_data = q.mem[q.rd[AW-1:0]];
  // push and pop pointers
  always_comb
  begin
    d = q;
    if (in_valid && in_ready)
    begin
      d.mem[q.wr[AW-1:0]] = in_data;
      d.wr = q.wr + (AW+1)'(1);
    end
    if (out_valid && out_ready)
    begin
      d.rd = q.rd + (AW+1)'(1);
    end
  end
  // state register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end
endmodule : chg_fifo

// ---- verilog/chg_target.sv ----
// register-file target end of the charger two-wire port
module chg_target (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  chg_i2c_if.tgt bus,
  // write stream towards the charger core
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // status
  output logic bus_busy
);
  import chg_pkg::*;

  typedef struct packed {
    chg_tst_t st;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] h0;
    logic [1:0] h1;
    logic [1:0] f;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic busy;
    logic nack;
    logic wpend;
    logic rpend;
    logic sda_low;
    logic scl_low;
    logic [REG_COUNT-1:0][7:0] regs;
  } chg_tgt_st_t;

  localparam chg_tgt_st_t TGT_RST = '{st: T_IDLE, s1: LINES_IDLE, s2: LINES_IDLE,
                                      h0: LINES_IDLE, h1: LINES_IDLE, f: LINES_IDLE,
                                      default: '0};

  chg_tgt_st_t q;
  chg_tgt_st_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic [FIFO_WIDTH-1:0] fifo_out;
  chg_wr_word_t in_word;
  chg_wr_word_t out_word;
  logic [7:0] rd_byte;

  // queued writes; a full queue stretches the clock
  chg_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(in_word),
    .out_valid(fifo_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  // pending write leaves once the queue has room
  assign push = q.wpend & fifo_ready;
  assign in_word = '{addr: q.ptr, data: q.sh};
  assign out_word = fifo_out;

  // user side outputs
  assign wr_valid = fifo_valid;
  assign wr_addr = out_word.addr;
  assign wr_data = out_word.data;
  assign bus_busy = q.busy;

  // open drain only: the driven level is always low
  assign bus.tgt_scl_o = 1'b0;
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_scl_oe_n = ~q.scl_low;
  assign bus.tgt_sda_oe_n = ~q.sda_low;

  // locations above the map read as all ones
  assign rd_byte = (q.ptr <= REG_LAST) ? q.regs[q.ptr[REG_IDX_W-1:0]] : RD_FILL;

  // line conditioning, events and the byte engine
  always_comb
  begin
    d = q;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;

    // two flops, then a three-sample agreement filter
    d.s1 = {bus.sda, bus.scl};
    d.s2 = q.s1;
    d.h0 = q.s2;
    d.h1 = q.h0;
    for (int i = 0; i < 2; i++)
    begin
      if ((q.s2[i] == q.h0[i]) && (q.h0[i] == q.h1[i]))
        d.f[i] = q.s2[i];
    end

    // edges of the filtered lines
    scl_rise = d.f[LN_SCL] & ~q.f[LN_SCL];
    scl_fall = ~d.f[LN_SCL] & q.f[LN_SCL];
    start_seen = q.f[LN_SCL] & d.f[LN_SCL] & q.f[LN_SDA] & ~d.f[LN_SDA];
    stop_seen = q.f[LN_SCL] & d.f[LN_SCL] & ~q.f[LN_SDA] & d.f[LN_SDA];

    // drained words update the map, so reads see them
    if (fifo_valid && wr_ready && (out_word.addr <= REG_LAST))
      d.regs[out_word.addr[REG_IDX_W-1:0]] = out_word.data;

    // clock goes free a cycle after the data moved, so data never races the rising clock
    if (q.scl_low && !q.wpend && !q.rpend)
      d.scl_low = 1'b0;

    // stretched write byte: hand over, then acknowledge
    if (push)
    begin
      d.wpend = 1'b0;
      d.sda_low = 1'b1;
      d.ptr = q.ptr + PTR_STEP;
    end

    // read load waits until queued writes reached the map
    if (q.rpend && !fifo_valid)
    begin
      d.rpend = 1'b0;
      d.sh = rd_byte;
      d.sda_low = ~rd_byte[7];
      d.ptr = q.ptr + PTR_STEP;
    end

    if (start_seen)
    begin
      // a start, repeated or not, always reopens address reception
      d.st = T_ADDR;
      d.bitn = '1; // the clock fall closing the start carries no bit
      d.busy = 1'b1;
      d.sda_low = 1'b0;
      d.scl_low = 1'b0;
      d.wpend = 1'b0;
      d.rpend = 1'b0;
    end
    else if (stop_seen)
    begin
      d.st = T_IDLE;
      d.busy = 1'b0;
      d.sda_low = 1'b0;
      d.scl_low = 1'b0;
      d.wpend = 1'b0;
      d.rpend = 1'b0;
    end
    else if (q.st != T_IDLE)
    begin
      // sample while clock high, data is stable then
      if (scl_rise)
      begin
        if ((q.bitn <= LAST_BIT) && (q.st != T_RDATA))
          d.sh = {q.sh[6:0], q.f[LN_SDA]};
        if ((q.bitn == ACK_BIT) && (q.st == T_RDATA))
          d.nack = q.f[LN_SDA];
      end

      // bit and ack driving changes happen right after a falling clock; stretched write and read loads drive later
      if (scl_fall)
      begin
        if (q.bitn < LAST_BIT)
        begin
          d.bitn = q.bitn + 4'h1;
          if (q.st == T_RDATA)
          begin
            d.sh = {q.sh[6:0], 1'b1};
            d.sda_low = ~q.sh[6];
          end
        end
        else if (q.bitn == LAST_BIT)
        begin
          d.bitn = ACK_BIT;
          unique case (q.st)
            T_ADDR:
            begin
              if (q.sh[7:1] == TGT_ADDR)
              begin
                d.sda_low = 1'b1;
                d.rw = q.sh[0];
              end
              else
                d.st = T_IDLE;
            end
            T_PTR:
            begin
              if (q.sh <= REG_LAST)
              begin
                d.sda_low = 1'b1;
                d.ptr = q.sh;
              end
              else
                d.st = T_IDLE;
            end
            T_WDATA:
            begin
              if (q.ptr <= REG_LAST)
              begin
                // hold clock low until the queue takes the byte
                d.wpend = 1'b1;
                d.scl_low = 1'b1;
              end
              else
              begin
                d.sda_low = 1'b1;
                d.ptr = q.ptr + PTR_STEP;
              end
            end
            T_RDATA: d.sda_low = 1'b0;
            T_IDLE: ;
          endcase
        end
        else if (q.bitn == ACK_BIT)
        begin
          // end of the ninth clock
          d.bitn = '0;
          d.sda_low = 1'b0;
          unique case (q.st)
            T_ADDR:
            begin
              if (q.rw)
              begin
                d.st = T_RDATA;
                d.rpend = 1'b1;
                d.scl_low = 1'b1;
              end
              else
                d.st = T_PTR;
            end
            T_PTR: d.st = T_WDATA;
            T_WDATA: ;
            T_RDATA:
            begin
              if (q.nack)
                d.st = T_IDLE;
              else
              begin
                d.rpend = 1'b1;
                d.scl_low = 1'b1;
              end
            end
            T_IDLE: ;
          endcase
        end
        else
          d.bitn = '0; // first bit of the address byte follows
      end
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      q <= TGT_RST;
    else
      q <= d;
  end

endmodule : chg_target

// ---- verilog/chg_controller.sv ----
// bus controller end of the charger two-wire port
module chg_controller (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link
  chg_i2c_if.ctl bus,
  // speed select: high for fast mode
  input wire logic fast_mode,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire chg_pkg::chg_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  // byte answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  import chg_pkg::*;
  typedef struct packed {
    chg_cst_t st;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] ph;
    logic [7:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic nack;
    logic scl_low;
    logic sda_low;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ack;
  } chg_ctl_st_t;
  localparam chg_ctl_st_t CTL_RST = '{st: C_IDLE, s1: LINES_IDLE, s2: LINES_IDLE,
                                      default: '0};
  chg_ctl_st_t q;
  chg_ctl_st_t d;
  logic [7:0] qlen;
  logic run;
  logic tick;
  assign cmd_ready = (q.st == C_IDLE);
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rsp_data;
  assign rsp_ack = q.rsp_ack;
  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe_n = ~q.scl_low;
  assign bus.ctl_sda_oe_n = ~q.sda_low;
  // quarter-bit divider; the wait quarter runs only once scl reads high
  assign qlen = fast_mode ? FAST_QTR : STD_QTR;
  assign run = (q.ph != PH_WAIT) || q.s2[LN_SCL];
  assign tick = run && (q.cnt == (qlen - 8'h01));
  // sequencer: data set, clock released, clock high, sample
  always_comb
  begin
    d = q;
    d.rsp_valid = 1'b0;
    d.s1 = {bus.sda, bus.scl};
    d.s2 = q.s1;
    if (q.st != C_IDLE && run)
      d.cnt = tick ? 8'h00 : q.cnt + 8'h01;
    if (cmd_valid && cmd_ready)
    begin
      d.ph = PH_SET;
      d.cnt = 8'h00;
      d.bitn = '0;
      d.rd = (cmd_op == OP_READ);
      d.nack = cmd_nack;
      d.sh = cmd_data;
      unique case (cmd_op)
        OP_START: d.st = C_START;
        OP_STOP: d.st = C_STOP;
        default: d.st = C_BYTE;
      endcase
    end
    else if (q.st != C_IDLE && tick)
    begin
      d.ph = q.ph + 2'h1;
      unique case (q.ph)
        PH_SET:
        begin
          // data moves a quarter after scl fell
          if (q.st == C_START)
            d.sda_low = 1'b0;
          else if (q.st == C_STOP)
            d.sda_low = 1'b1;
          else if (q.bitn == ACK_BIT)
            d.sda_low = q.rd & ~q.nack;
          else
            d.sda_low = ~q.rd & ~q.sh[7];
        end
        PH_LOW: d.scl_low = 1'b0;
        PH_WAIT:
        begin
          if (q.st == C_START)
            d.sda_low = 1'b1;
          else if (q.st == C_STOP)
            d.sda_low = 1'b0;
        end
        PH_HIGH:
        begin
          if (q.st == C_STOP)
            d.st = C_IDLE;
          else
          begin
            d.scl_low = 1'b1;
            if (q.st == C_START)
              d.st = C_IDLE;
            else if (q.bitn == ACK_BIT)
            begin
              // low ack bit reads as acknowledge
              d.rsp_ack = ~q.s2[LN_SDA];
              d.rsp_data = q.sh;
              d.rsp_valid = 1'b1;
              d.st = C_IDLE;
            end
            else
            begin
              d.sh = {q.sh[6:0], q.s2[LN_SDA]};
              d.bitn = q.bitn + 4'h1;
            end
          end
        end
      endcase
    end
  end
  // state register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      q <= CTL_RST;
    else
      q <= d;
  end
endmodule : chg_controller

// ---- bench/chg_monitor.sv ----
// link checker for the two-wire port, fed with the driven and resolved lines
module chg_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // controller drive
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe_n,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_n,
  // target drive
  input wire logic tgt_scl_o,
  input wire logic tgt_scl_oe_n,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe_n,
  // resolved lines
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  import chg_pkg::*;
  logic scl_q, sda_q, first_q;
  logic [3:0] nbit_q;
  logic [7:0] sh_q;
  // line history, clock rises since start, byte shifted in so far
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b0;
      nbit_q <= 4'h0;
      sh_q <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        nbit_q <= 4'h0;
        first_q <= 1'b1;
      end
      else if (scl && !scl_q)
      begin
        nbit_q <= (nbit_q == 4'h9) ? 4'h1 : nbit_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
        if (nbit_q == 4'h8)
          first_q <= 1'b0;
      end
    end
  end
  // single domain, so clock and disable are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_ninth;
    scl && !scl_q && nbit_q == 4'h8;
  endsequence
  sequence s_addr_byte;
    s_ninth ##0 first_q;
  endsequence
  sequence s_stop;
    scl && scl_q && sda && !sda_q;
  endsequence
  a_drive_low_only: assert property (!ctl_scl_o && !ctl_sda_o && !tgt_scl_o && !tgt_sda_o)
    else $error("a line was driven high");
  a_tgt_data_steady: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe_n))
    else $error("target moved data while clock high");
  a_cond_by_ctl: assert property (scl && $past(scl) && $changed(sda) |-> $changed(ctl_sda_oe_n))
    else $error("start or stop not made by controller");
  a_ack_held: assert property ($rose(scl) && !tgt_sda_oe_n |-> !tgt_sda_oe_n throughout (##[1:300] !scl))
    else $error("target low data not held over high phase");
  a_ninth_release: assert property (s_ninth |-> ctl_sda_oe_n || tgt_sda_oe_n)
    else $error("both ends pulled data at ninth clock");
  a_addr_match: assert property (s_addr_byte ##0 (sh_q[7:1] == TGT_ADDR) |-> !tgt_sda_oe_n)
    else $error("own address not acknowledged");
  a_addr_ignore: assert property (s_addr_byte ##0 (sh_q[7:1] != TGT_ADDR) |-> tgt_sda_oe_n)
    else $error("foreign address acknowledged");
  a_stretch_on_low: assert property ($fell(tgt_scl_oe_n) |-> !$past(scl))
    else $error("target pulled clock while it was high");
  a_clk_by_ctl: assert property ($fell(scl) |-> $fell(ctl_scl_oe_n))
    else $error("clock fall not made by controller");
  a_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_stop_idle: assert property (s_stop |=> (scl && sda) [*4])
    else $error("lines not idle after stop");
endmodule : chg_monitor

// ---- bench/tb_top.sv ----
// self-checking bench joining the controller and target ends over the link
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import chg_pkg::*;
  logic clock, reset, fast_mode, cmd_valid, cmd_nack, wr_ready;
  logic cmd_ready, rsp_valid, rsp_ack, wr_valid, bus_busy;
  chg_op_t cmd_op;
  logic [7:0] cmd_data, rsp_data, wr_addr, wr_data;
  logic [7:0] map [REG_COUNT];
  logic [15:0] wq [$];
  logic [6:0] bad_ta;
  int mismatches, checks_done, cycles, rdy_mode, seed, rseed;
  chg_i2c_if link ();
  // both ends under test plus the link checker
  chg_controller i_chg_controller (.clock(clock), .reset(reset), .bus(link.ctl),
    .fast_mode(fast_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack));
  chg_target i_chg_target (.clock(clock), .reset(reset), .bus(link.tgt), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .bus_busy(bus_busy));
  chg_monitor i_chg_monitor (.clock(clock), .reset(reset), .ctl_scl_o(link.ctl_scl_o),
    .ctl_scl_oe_n(link.ctl_scl_oe_n), .ctl_sda_o(link.ctl_sda_o),
    .ctl_sda_oe_n(link.ctl_sda_oe_n), .tgt_scl_o(link.tgt_scl_o),
    .tgt_scl_oe_n(link.tgt_scl_oe_n), .tgt_sda_o(link.tgt_sda_o),
    .tgt_sda_oe_n(link.tgt_sda_oe_n), .scl(link.scl), .sda(link.sda));
  // 20 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one command held until taken; byte commands then wait for their answer
  task automatic xfer(input chg_op_t op, input logic [7:0] d, input logic nk);
    int n;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1)
      tick();
    tick();
    cmd_valid = 1'b0;
    n = 0;
    while (n < 6000 && ((op < OP_WRITE) ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1))
    begin
      tick();
      n++;
    end
    if (n == 6000)
    begin
      mismatches++;
      $display("Error command cycles expected %0d seen %0d", 5999, n);
    end
  endtask : xfer
  // what a read of pointer p must return
  function automatic logic [7:0] exp_rd(input int p);
    return (p <= REG_LAST) ? map[p] : RD_FILL;
  endfunction : exp_rd
  // address, pointer, wl random data bytes, then restart and rl reads
  task automatic txn(input logic [6:0] ta, input logic [7:0] ptr, input int wl, input int rl);
    logic [7:0] d;
    xfer(OP_START, 8'h00, 1'b0);
    xfer(OP_WRITE, {ta, 1'b0}, 1'b0);
    check("addr ack", 8'(ta == TGT_ADDR), 8'(rsp_ack));
    check("busy", 8'h01, 8'(bus_busy));
    if (ta == TGT_ADDR)
    begin
      xfer(OP_WRITE, ptr, 1'b0);
      check("ptr ack", 8'(ptr <= REG_LAST), 8'(rsp_ack));
      for (int i = 0; i < wl && ptr <= REG_LAST; i++)
      begin
        d = 8'($random(seed));
        if (ptr + i <= REG_LAST)
        begin
          map[ptr + i] = d;
          wq.push_back({8'(ptr + i), d});
        end
        xfer(OP_WRITE, d, 1'b0);
        check("data ack", 8'h01, 8'(rsp_ack));
      end
      if (rl > 0 && ptr <= REG_LAST)
      begin
        xfer(OP_START, 8'h00, 1'b0);
        xfer(OP_WRITE, {TGT_ADDR, 1'b1}, 1'b0);
        check("read addr ack", 8'h01, 8'(rsp_ack));
        for (int i = 0; i < rl; i++)
        begin
          xfer(OP_READ, 8'hff, i == rl - 1);
          check("read data", exp_rd(ptr + i), rsp_data);
        end
      end
    end
    xfer(OP_STOP, 8'h00, 1'b0);
    for (int n = 0; n < 20 && bus_busy !== 1'b0; n++)
      tick();
    check("free", 8'h00, 8'(bus_busy));
    $display("transfer to %h at %h done", ta, ptr);
  endtask : txn
  // write stream sink: ready held low, random, or held high
  always @(posedge clock)
  begin
    #1;
    wr_ready = (rdy_mode == 2) || (rdy_mode == 1 && 1'($random(rseed)));
  end
  // popped words must come in write order with the written bytes
  always @(posedge clock)
    if (reset === 1'b0 && wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      check("pop addr", wq[0][15:8], wr_addr);
      check("pop data", wq[0][7:0], wr_data);
      void'(wq.pop_front());
    end
  // hang guard, well above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      $display("Error run length expected %0d seen %0d", 89999, cycles);
      give_verdict();
    end
  end
  // reset, then the scenarios in turn
  initial
  begin
    seed = 32'h7d778812;
    rseed = seed;
    reset = 1'b1;
    fast_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    wr_ready = 1'b1;
    rdy_mode = 2;
    foreach (map[i])
      map[i] = 8'h00;
    repeat (12) @(posedge clock);
    #1;
    reset = 1'b0;
    tick();
    // standard rate: foreign addresses, undefined pointer, read over the top
    bad_ta = 7'($random(seed));
    if (bad_ta == TGT_ADDR)
      bad_ta = 7'h00;
    txn(7'h6a, 8'h00, 0, 0);
    txn(bad_ta, 8'h00, 0, 0);
    txn(TGT_ADDR, 8'h26, 0, 0);
    txn(TGT_ADDR, 8'h24, 0, 3);
    // fast rate: fill the buffer until the target stretches, then drain
    fast_mode = 1'b1;
    rdy_mode = 0;
    fork
      txn(TGT_ADDR, 8'h00, 40, 0);
      begin
        while (wq.size() < 33)
          tick();
        repeat (800) tick();
        check("stretched clock", 8'h00, 8'(link.scl));
        check("target clock drive", 8'h00, 8'(link.tgt_scl_oe_n));
        rdy_mode = 1;
      end
    join
    for (int n = 0; n < 200 && wr_valid !== 1'b0; n++)
      tick();
    check("drained", 8'h00, 8'(wr_valid));
    check("words left", 8'h00, 8'(wq.size()));
    txn(TGT_ADDR, 8'h00, 0, 40);
    give_verdict();
  end
endmodule : tb_top
